// File: rtl/bds_pkg.sv
// Package for the brushless drive supervisor: states, fault flags, setup.
package bds_pkg;

    typedef enum {
        ST_INIT_CFG,
        ST_INIT_START,
        ST_STOP,
        ST_ENABLE,
        ST_RUN,
        ST_DISABLE,
        ST_MOTOR_FAULT,
        ST_GLOBAL_FAULT
    } bds_state_t;

    // Sticky fault flags
    typedef struct packed {
        logic overcurrent;
        logic microcode_exception;
        logic illegal_instruction;
        logic code_memory_check;
    } bds_faults_t;

    // Global exception sources
    typedef struct packed {
        logic flag_microcode_exception;
        logic flag_illegal_instruction;
        logic code_memory_check;
    } bds_gexc_t;

    // Static coprocessor configuration driven out during initialisation
    typedef struct packed {
        logic [1:0] filter_mode;
        logic [7:0] filter_div;
        logic [7:0] tb_fast_div;
        logic [7:0] tb_fast_presc;
        logic [7:0] tb_slow_div;
        logic [7:0] tb_slow_presc;
        logic [4:0] ch_hall_a;
        logic [4:0] ch_hall_b;
        logic [4:0] ch_hall_c;
        logic [4:0] ch_fault_in;
        logic [4:0] ch_speed_ctl;
        logic [4:0] ch_pwm_master;
        logic [4:0] ch_pwm_a;
        logic [4:0] ch_pwm_b;
        logic [4:0] ch_pwm_c;
        logic [4:0] ch_pwm_a_n;
        logic [4:0] ch_pwm_b_n;
        logic [4:0] ch_pwm_c_n;
        logic fault_prio_high;
        logic compl_pairs;
        logic [15:0] pwm_freq_hz;
        logic [15:0] dead_time_ns;
        logic [15:0] speed_range_rpm;
        logic [15:0] speed_min_rpm;
        logic [3:0] pole_pairs;
        logic [15:0] sc_freq_hz;
        logic [23:0] sc_p_gain;
        logic [23:0] sc_i_gain;
        logic [15:0] ramp_up_ms;
        logic [15:0] ramp_down_ms;
    } bds_cfg_t;

    localparam logic [1:0] FILTER_THREE_SAMPLE = 2'h1;
    localparam logic [7:0] FILTER_CLK_DIV = 8'h20;
    localparam logic [7:0] TB_FAST_DIV = 8'h02;
    localparam logic [7:0] TB_FAST_PRESC = 8'h01;
    localparam logic [7:0] TB_SLOW_DIV = 8'h08;
    localparam logic [7:0] TB_SLOW_PRESC = 8'h0c;
    localparam logic [4:0] CH_HALL_A = 5'h01;
    localparam logic [4:0] CH_HALL_B = 5'h02;
    localparam logic [4:0] CH_HALL_C = 5'h03;
    localparam logic [4:0] CH_FAULT_IN = 5'h04;
    localparam logic [4:0] CH_SPEED_CTL = 5'h05;
    localparam logic [4:0] CH_PWM_MASTER = 5'h07;
    localparam logic [4:0] CH_PWM_A = 5'h08;
    localparam logic [4:0] CH_PWM_B = 5'h0a;
    localparam logic [4:0] CH_PWM_C = 5'h0c;
    localparam logic [4:0] CH_COMPL_STEP = 5'h01;
    localparam logic [15:0] PWM_FREQ_HZ = 16'h4e20;      // 20 kHz
    localparam logic [15:0] DEAD_TIME_NS = 16'h03e8;     // 1 us
    localparam logic [15:0] SPEED_RANGE_RPM = 16'h36b0;  // 14000
    localparam logic [15:0] SPEED_MIN_RPM = 16'h012c;    // 300
    localparam logic [3:0] POLE_PAIRS = 4'h4;
    localparam logic [15:0] SC_FREQ_HZ = 16'h2710;       // 10 kHz
    localparam logic [23:0] SC_P_GAIN = 24'h004000;
    localparam logic [23:0] SC_I_GAIN = 24'h000100;
    localparam logic [15:0] RAMP_MS = 16'h07d0;          // 2 s

    // Filter and timebase figures at the 75 MHz reference clock
    localparam int FILTER_REJECT_NS = 853;
    localparam int FILTER_PASS_NS = 1280;
    localparam int TB_FAST_KHZ = 37500;
    localparam int TB_SLOW_HZ = 781250;

    // Supervisor clock
    localparam int MCLK_PERIOD_NS = 4;

endpackage

// File: rtl/bds_supervisor.sv
// Brushless drive supervisor: state machine, fault handling, setup outputs.
// How it works
// - After reset initialise, then stop if switch off, else motor fault.
// - Stop and run are joined only through enabling or disabling states.
// - Over-current forces motor fault; switch off returns to stop.
// - Global exception forces global fault; switch off re-initialises.
// - Over-current: clear speed, PWM off, fault lamp on, fault state, flag.
// - Any of three exception sources raises global fault; matching flag set.
// - Global exception: clear speed, PWM off, global fault; lamp keeps its value.
// - Transient initialisation configures, starts link and coprocessor, branches.
// - PWM master on channel 7 pulses once per PWM period.
// - Over-current enters on channel 4, high priority general input.
// - Hall filters: three samples, clock divided by 32.
// - Fast timebase: clock divided by 2, prescaler 1.
// - Slow timebase: clock divided by 8, prescaler 12.
// - Hall 1-3, speed 5, master 7, phases A-C on 8, 10, 12.
// - Complementary pairs at 20 kHz with 1 us dead time.
// - Speed from revolution period, 4 pole pairs, 14000 range, 300 minimum.
// - PI at 10 kHz, gains 0x004000 and 0x000100 scaled by 2^-15.
// - Speed ramps take 2 s up and 2 s down.
// - Interrupt enables and output disables first, then timebases enabled.
// - Periodic tick samples switch and advances the state machine.
// - Enabling clears speed, enables PWM, arms fault edge on success.
// - Disabling clears speed, disables PWM, stops only on success.
// - Complementary output sits one channel above its base channel.
`timescale 1ns/1ps

module bds_supervisor
    import bds_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Operator controls
    input wire logic switch_on,
    input wire logic tick,
    input wire logic [15:0] speed_set_rpm,
    // Fault sources
    input wire logic overcurrent_in,
    input wire bds_gexc_t gexc_in,
    // Coprocessor handshakes
    input wire logic pwm_period_in,
    input wire logic pwm_ack,
    input wire logic pwm_ok,
    input wire logic cfg_done,
    // Drive outputs
    output bds_state_t state_q,
    output logic pwm_en_q,
    output logic pwm_req_q,
    output logic [15:0] speed_req_q,
    output logic fault_led_q,
    output logic fault_arm_q,
    output bds_faults_t faults_q,
    // Coprocessor setup and start
    output bds_cfg_t cfg_q,
    output logic cfg_load_q,
    output logic link_init_q,
    output logic irq_cfg_q,
    output logic tb_en_q,
    output logic sample_q
);

    logic switch_q;
    logic oc_evt;
    logic ge_evt;
    logic start_step_q;

    // Outside initialisation the switch is only looked at on the tick, like the periodic task
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            switch_q <= 1'b0;
        end else if (tick) begin
            switch_q <= switch_on;
        end
    end

    // The fault input is armed only in run and the first disabling cycle, so it cannot trip stop
    assign oc_evt = overcurrent_in && fault_arm_q;
    assign ge_evt = |gexc_in;

    // Main state machine
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ST_INIT_CFG;
        end else if (ge_evt) begin
            state_q <= ST_GLOBAL_FAULT;
        end else if (oc_evt && state_q != ST_GLOBAL_FAULT) begin
            state_q <= ST_MOTOR_FAULT;
        end else begin
            case (state_q)
                ST_INIT_CFG: begin
                    if (cfg_done) begin
                        state_q <= ST_INIT_START;
                    end
                end
                ST_INIT_START: begin
                    if (start_step_q) begin
                        state_q <= switch_on ? ST_MOTOR_FAULT : ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tick && switch_q) begin
                        state_q <= ST_ENABLE;
                    end
                end
                ST_ENABLE: begin
                    if (pwm_ack && pwm_ok) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (tick && !switch_q) begin
                        state_q <= ST_DISABLE;
                    end
                end
                ST_DISABLE: begin
                    if (pwm_ack && pwm_ok) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_MOTOR_FAULT: begin
                    if (tick && !switch_q) begin
                        state_q <= ST_STOP;
                    end
                end
                ST_GLOBAL_FAULT: begin
                    if (tick && !switch_q) begin
                        state_q <= ST_INIT_CFG;
                    end
                end
                default: begin
                    state_q <= ST_INIT_CFG;
                end
            endcase
        end
    end

    // Start order: interrupt and output-disable setup, then timebases
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_cfg_q <= 1'b0;
            tb_en_q <= 1'b0;
            start_step_q <= 1'b0;
        end else if (state_q == ST_INIT_CFG) begin
            irq_cfg_q <= 1'b0;
            tb_en_q <= 1'b0;
            start_step_q <= 1'b0;
        end else if (state_q == ST_INIT_START) begin
            irq_cfg_q <= 1'b1;
            start_step_q <= irq_cfg_q;
            tb_en_q <= irq_cfg_q;
        end
    end

    // Configuration loaded once per initialisation
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_load_q <= 1'b0;
            link_init_q <= 1'b0;
        end else begin
            cfg_load_q <= (state_q == ST_INIT_CFG) && !cfg_done;
            link_init_q <= (state_q == ST_INIT_CFG) && cfg_done;
        end
    end

    // Speed request and PWM control
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            speed_req_q <= '0;
            pwm_en_q <= 1'b0;
            pwm_req_q <= 1'b0;
        end else if (ge_evt) begin
            speed_req_q <= '0;
            pwm_en_q <= 1'b0;
            pwm_req_q <= 1'b0;
        end else if (oc_evt) begin
            speed_req_q <= '0;
            pwm_en_q <= 1'b0;
            pwm_req_q <= 1'b0;
        end else begin
            case (state_q)
                ST_ENABLE: begin
                    speed_req_q <= '0;
                    pwm_req_q <= !pwm_ack;
                    if (pwm_ack && pwm_ok) begin
                        pwm_en_q <= 1'b1;
                    end
                end
                ST_DISABLE: begin
                    speed_req_q <= '0;
                    pwm_req_q <= !pwm_ack;
                    if (pwm_ack && pwm_ok) begin
                        pwm_en_q <= 1'b0;
                    end
                end
                ST_RUN: begin
                    pwm_req_q <= 1'b0;
                    if (tick) begin
                        speed_req_q <= speed_set_rpm;
                    end
                end
                default: begin
                    pwm_req_q <= 1'b0;
                    speed_req_q <= '0;
                end
            endcase
        end
    end

    // Fault input armed for rising edge after a good enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_arm_q <= 1'b0;
        end else if (ge_evt || oc_evt || state_q == ST_DISABLE) begin
            fault_arm_q <= 1'b0;
        end else if (state_q == ST_ENABLE && pwm_ack && pwm_ok) begin
            fault_arm_q <= 1'b1;
        end
    end

    // Fault lamp and sticky flags; cleared on leaving the fault by switch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fault_led_q <= 1'b0;
            faults_q <= '0;
        end else begin
            if (oc_evt && !ge_evt) begin
                fault_led_q <= 1'b1;
                faults_q.overcurrent <= 1'b1;
            end else if (!ge_evt && state_q == ST_MOTOR_FAULT && tick
                    && !switch_q) begin
                // A global exception on the exit tick keeps lamp and flag
                fault_led_q <= 1'b0;
                faults_q.overcurrent <= 1'b0;
            end
            if (ge_evt) begin
                faults_q.microcode_exception <=
                    gexc_in.flag_microcode_exception;
                faults_q.illegal_instruction <=
                    gexc_in.flag_illegal_instruction;
                faults_q.code_memory_check <= gexc_in.code_memory_check;
            end else if (state_q == ST_GLOBAL_FAULT && tick && !switch_q) begin
                faults_q.microcode_exception <= 1'b0;
                faults_q.illegal_instruction <= 1'b0;
                faults_q.code_memory_check <= 1'b0;
            end
        end
    end

    // Sampling strobe once per PWM period from the master channel
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= pwm_period_in;
        end
    end

    // Fixed coprocessor setup
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else begin
            cfg_q.filter_mode <= FILTER_THREE_SAMPLE;
            cfg_q.filter_div <= FILTER_CLK_DIV;
            cfg_q.tb_fast_div <= TB_FAST_DIV;
            cfg_q.tb_fast_presc <= TB_FAST_PRESC;
            cfg_q.tb_slow_div <= TB_SLOW_DIV;
            cfg_q.tb_slow_presc <= TB_SLOW_PRESC;
            cfg_q.ch_hall_a <= CH_HALL_A;
            cfg_q.ch_hall_b <= CH_HALL_B;
            cfg_q.ch_hall_c <= CH_HALL_C;
            cfg_q.ch_fault_in <= CH_FAULT_IN;
            cfg_q.fault_prio_high <= 1'b1;
            cfg_q.ch_speed_ctl <= CH_SPEED_CTL;
            cfg_q.ch_pwm_master <= CH_PWM_MASTER;
            cfg_q.ch_pwm_a <= CH_PWM_A;
            cfg_q.ch_pwm_b <= CH_PWM_B;
            cfg_q.ch_pwm_c <= CH_PWM_C;
            cfg_q.ch_pwm_a_n <= CH_PWM_A + CH_COMPL_STEP;
            cfg_q.ch_pwm_b_n <= CH_PWM_B + CH_COMPL_STEP;
            cfg_q.ch_pwm_c_n <= CH_PWM_C + CH_COMPL_STEP;
            cfg_q.compl_pairs <= 1'b1;
            cfg_q.pwm_freq_hz <= PWM_FREQ_HZ;
            cfg_q.dead_time_ns <= DEAD_TIME_NS;
            cfg_q.speed_range_rpm <= SPEED_RANGE_RPM;
            cfg_q.speed_min_rpm <= SPEED_MIN_RPM;
            cfg_q.pole_pairs <= POLE_PAIRS;
            cfg_q.sc_freq_hz <= SC_FREQ_HZ;
            cfg_q.sc_p_gain <= SC_P_GAIN;
            cfg_q.sc_i_gain <= SC_I_GAIN;
            cfg_q.ramp_up_ms <= RAMP_MS;
            cfg_q.ramp_down_ms <= RAMP_MS;
        end
    end

    // Checks
    sequence s_oc_hit;
        oc_evt && !ge_evt;
    endsequence

    a_reset_to_init: assert property (@(posedge mclk)
        !rst_n |=> state_q == ST_INIT_CFG)
        else $error("reset did not enter init");
    a_run_from_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_RUN && $past(state_q) != ST_RUN) |->
        $past(state_q) == ST_ENABLE)
        else $error("run entered not from enable");
    a_oc_fault_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        s_oc_hit |=> state_q == ST_MOTOR_FAULT && fault_led_q
        && faults_q.overcurrent && !pwm_en_q && speed_req_q == '0)
        else $error("over-current handling wrong");
    a_ge_fault_entry: assert property (@(posedge mclk) disable iff (!rst_n)
        ge_evt |=> state_q == ST_GLOBAL_FAULT && !pwm_en_q
        && speed_req_q == '0 && fault_led_q == $past(fault_led_q))
        else $error("global exception handling wrong");
    a_ge_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        ge_evt |=> faults_q.illegal_instruction
        == $past(gexc_in.flag_illegal_instruction))
        else $error("exception flag mismatch");
    a_start_order: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(tb_en_q) |-> $past(irq_cfg_q))
        else $error("timebase enabled before setup");
    a_disable_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_DISABLE && !(pwm_ack && pwm_ok) && !ge_evt && !oc_evt)
        |=> state_q == ST_DISABLE)
        else $error("disable left without success");
    a_enable_arm: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_q == ST_ENABLE && pwm_ack && pwm_ok && !ge_evt && !oc_evt)
        |=> fault_arm_q && pwm_en_q && state_q == ST_RUN)
        else $error("enable did not arm fault input");
    a_ge_priority: assert property (@(posedge mclk) disable iff (!rst_n)
        (ge_evt && oc_evt) |=> state_q == ST_GLOBAL_FAULT)
        else $error("fault priority wrong");
    a_sample_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        pwm_period_in |=> sample_q)
        else $error("period strobe lost");

endmodule

// File: verif/bds_copro_model.sv
// Coprocessor stand-in: PWM enable handshake, setup done, period pulse.
`timescale 1ns/1ps

module bds_copro_model #(
    parameter int PERIOD = 50,
    parameter int CFG_DLY = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Requests from the supervisor
    input wire logic pwm_req,
    input wire logic cfg_load,
    // Behaviour selection
    input wire logic slow,
    input wire logic refuse,
    // Answers
    output logic pwm_ack,
    output logic pwm_ok,
    output logic cfg_done,
    output logic pwm_period
);
    logic [7:0] cnt;
    logic [7:0] ccnt;
    logic [7:0] pcnt;

    // Ok toggles outside an ack so a late sample never sees a stale pass
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            pwm_ack <= 1'b0;
            pwm_ok <= 1'b0;
        end else begin
            pwm_ok <= ~pwm_ok;
            if (pwm_ack) begin
                pwm_ack <= 1'b0;
                cnt <= 8'h00;
            end else if (pwm_req) begin
                if (cnt >= (slow ? 8'h06 : 8'h00)) begin
                    pwm_ack <= 1'b1;
                    pwm_ok <= ~refuse;
                end else begin
                    cnt <= cnt + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ccnt <= 8'h00;
            cfg_done <= 1'b0;
        end else begin
            cfg_done <= 1'b0;
            if (cfg_load && !cfg_done) begin
                if (ccnt == 8'(CFG_DLY)) begin
                    cfg_done <= 1'b1;
                    ccnt <= 8'h00;
                end else begin
                    ccnt <= ccnt + 8'h01;
                end
            end else begin
                ccnt <= 8'h00;
            end
        end
    end

    // Period shortened from the real 20 kHz to keep the run brief
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pcnt <= 8'h00;
            pwm_period <= 1'b0;
        end else begin
            pcnt <= (pcnt == 8'(PERIOD - 1)) ? 8'h00 : pcnt + 8'h01;
            pwm_period <= (pcnt == 8'(PERIOD - 1));
        end
    end
endmodule

// File: verif/bds_supervisor_bench.sv
// Self-checking bench for the brushless drive supervisor.
`timescale 1ns/1ps

module bds_supervisor_bench
    import bds_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic switch_on = 1'b0;
    logic tick = 1'b0;
    logic [15:0] speed_set_rpm = 16'h0321;
    logic overcurrent_in = 1'b0;
    bds_gexc_t gexc_in = '0;
    logic pwm_period_in, pwm_ack, pwm_ok, cfg_done;
    logic slow = 1'b0;
    logic refuse = 1'b0;
    logic tick_en = 1'b1;
    logic tick_man = 1'b0;
    bds_state_t state_q, prv_st;
    logic pwm_en_q, pwm_req_q, fault_led_q, fault_arm_q;
    logic [15:0] speed_req_q;
    bds_faults_t faults_q;
    bds_cfg_t cfg_q;
    logic cfg_load_q, link_init_q, irq_cfg_q, tb_en_q, sample_q;
    int errors = 0;
    int n_tests = 0;
    logic [7:0] tcnt = 8'h00;
    logic per_q = 1'b0;
    logic irq_q = 1'b0;
    logic tb_q = 1'b0;
    logic link_seen = 1'b0;
    logic [1:0] rst_sr = 2'b00;
    bds_cfg_t exp_cfg = '{FILTER_THREE_SAMPLE, 8'h20, 8'h02, 8'h01, 8'h08,
        8'h0c, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h08, 5'h0a, 5'h0c,
        5'h09, 5'h0b, 5'h0d, 1'b1, 1'b1, 16'h4e20, 16'h03e8, 16'h36b0,
        16'h012c, 4'h4, 16'h2710, 24'h004000, 24'h000100, 16'h07d0, 16'h07d0};

    always #2 mclk = ~mclk;

    bds_supervisor uut (.mclk(mclk), .rst_n(rst_n), .switch_on(switch_on),
        .tick(tick), .speed_set_rpm(speed_set_rpm),
        .overcurrent_in(overcurrent_in), .gexc_in(gexc_in),
        .pwm_period_in(pwm_period_in), .pwm_ack(pwm_ack), .pwm_ok(pwm_ok),
        .cfg_done(cfg_done), .state_q(state_q), .pwm_en_q(pwm_en_q),
        .pwm_req_q(pwm_req_q), .speed_req_q(speed_req_q),
        .fault_led_q(fault_led_q), .fault_arm_q(fault_arm_q),
        .faults_q(faults_q), .cfg_q(cfg_q), .cfg_load_q(cfg_load_q),
        .link_init_q(link_init_q), .irq_cfg_q(irq_cfg_q),
        .tb_en_q(tb_en_q), .sample_q(sample_q));

    bds_copro_model copro (.mclk(mclk), .rst_n(rst_n), .pwm_req(pwm_req_q),
        .cfg_load(cfg_load_q), .slow(slow), .refuse(refuse),
        .pwm_ack(pwm_ack), .pwm_ok(pwm_ok), .cfg_done(cfg_done),
        .pwm_period(pwm_period_in));

    task automatic chk(input logic [$bits(bds_cfg_t)-1:0] seen, exp,
                       input string msg);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_of_test;
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Tick strobe every 8 cycles; also watches ordering on every edge
    always @(posedge mclk) begin
        rst_sr <= {rst_sr[0], rst_n};
        per_q <= pwm_period_in;
        irq_q <= irq_cfg_q;
        tb_q <= tb_en_q;
        prv_st <= state_q;
        if (link_init_q)
            link_seen <= 1'b1;
        if (rst_sr == 2'b11) begin
            chk(sample_q, per_q, "period sample");
            if (tb_en_q && !tb_q)
                chk(irq_q, 1'b1, "timebase before irq setup");
            if (prv_st == ST_STOP)
                chk(state_q == ST_RUN, 1'b0, "stop straight to run");
            if (prv_st == ST_RUN)
                chk(state_q == ST_STOP, 1'b0, "run straight to stop");
        end
        tick <= tick_en ? (tcnt[2:0] == 3'h7) : tick_man;
        tcnt <= tcnt + 8'h01;
    end

    task automatic wait_st(input bds_state_t s, input int lim,
                           input string msg);
        for (int i = 0; i < lim; i++) begin
            @(posedge mclk);
            #1;
            if (state_q === s)
                break;
        end
        chk(state_q, s, msg);
    endtask

    task automatic hold_st(input bds_state_t s, input string msg);
        repeat (30) @(posedge mclk);
        #1;
        chk(state_q, s, msg);
    endtask

    task automatic to_run;
        @(posedge mclk);
        switch_on <= 1'b1;
        wait_st(ST_ENABLE, 60, "enable");
        wait_st(ST_RUN, 60, "run");
        repeat (12) @(posedge mclk);
    endtask

    task automatic t_init;
        repeat (2) @(posedge mclk);
        #1;
        chk(state_q, ST_INIT_CFG, "init state");
        chk(cfg_load_q, 1'b1, "config load");
        wait_st(ST_STOP, 40, "stop after init");
        chk(link_seen, 1'b1, "link setup");
        chk({irq_cfg_q, tb_en_q}, 2'b11, "coprocessor started");
        chk(cfg_q, exp_cfg, "setup");
    endtask

    task automatic t_enable_disable;
        @(posedge mclk);
        refuse <= 1'b1;
        slow <= 1'b1;
        switch_on <= 1'b1;
        wait_st(ST_ENABLE, 60, "enable");
        hold_st(ST_ENABLE, "refused enable");
        @(posedge mclk);
        refuse <= 1'b0;
        wait_st(ST_RUN, 40, "run");
        chk(speed_req_q, 16'h0000, "speed cleared at enable");
        chk({pwm_en_q, fault_arm_q}, 2'b11, "pwm on and armed");
        repeat (12) @(posedge mclk);
        #1;
        chk(speed_req_q, 16'h0321, "speed copy");
        @(posedge mclk);
        refuse <= 1'b1;
        switch_on <= 1'b0;
        wait_st(ST_DISABLE, 60, "disable");
        hold_st(ST_DISABLE, "refused disable");
        chk(speed_req_q, 16'h0000, "speed cleared at disable");
        @(posedge mclk);
        refuse <= 1'b0;
        slow <= 1'b0;
        wait_st(ST_STOP, 40, "stop");
        chk(pwm_en_q, 1'b0, "pwm off");
    endtask

    task automatic t_overcurrent;
        @(posedge mclk);
        overcurrent_in <= 1'b1;
        repeat (3) @(posedge mclk);
        overcurrent_in <= 1'b0;
        #1;
        chk(state_q, ST_STOP, "unarmed fault input");
        to_run;
        @(posedge mclk);
        overcurrent_in <= 1'b1;
        @(posedge mclk);
        overcurrent_in <= 1'b0;
        #1;
        chk(state_q, ST_MOTOR_FAULT, "motor fault");
        chk({fault_led_q, faults_q, pwm_en_q, fault_arm_q}, 7'h60, "fault out");
        chk(speed_req_q, 16'h0000, "speed cleared on fault");
        hold_st(ST_MOTOR_FAULT, "fault holds with switch on");
        @(posedge mclk);
        switch_on <= 1'b0;
        wait_st(ST_STOP, 60, "fault cleared");
        to_run;
        // Manual ticks: the first drops switch_q, the second would leave
        // run by switch in the very cycle the fault arrives
        @(posedge mclk);
        tick_en <= 1'b0;
        @(posedge mclk);
        switch_on <= 1'b0;
        tick_man <= 1'b1;
        repeat (2) @(posedge mclk);
        tick_man <= 1'b0;
        overcurrent_in <= 1'b1;
        @(posedge mclk);
        overcurrent_in <= 1'b0;
        #1;
        chk(state_q, ST_MOTOR_FAULT, "fault beats switch");
        @(posedge mclk);
        tick_en <= 1'b1;
        wait_st(ST_STOP, 60, "fault cleared");
    endtask

    task automatic t_global;
        for (int i = 0; i < 3; i++) begin
            to_run;
            @(posedge mclk);
            gexc_in <= bds_gexc_t'(3'b100 >> i);
            // First pass also trips over-current: the exception must win
            overcurrent_in <= (i == 0);
            @(posedge mclk);
            gexc_in <= '0;
            overcurrent_in <= 1'b0;
            #1;
            chk(state_q, ST_GLOBAL_FAULT, "global fault");
            chk({faults_q, fault_led_q, pwm_en_q},
                {1'b0, 3'b100 >> i, 2'b00}, "global flags");
            chk(speed_req_q, 16'h0000, "speed cleared");
            @(posedge mclk);
            switch_on <= 1'b0;
            wait_st(ST_INIT_CFG, 60, "re-initialise");
            if (i == 2) begin
                @(posedge mclk);
                switch_on <= 1'b1;
                wait_st(ST_MOTOR_FAULT, 20, "init with switch on");
                @(posedge mclk);
                switch_on <= 1'b0;
            end
            wait_st(ST_STOP, 60, "stop");
        end
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_init;
        t_enable_disable;
        t_overcurrent;
        t_global;
        end_of_test;
    end

    // Whole run needs roughly 500 cycles
    initial begin
        repeat (6000) @(posedge mclk);
        errors++;
        end_of_test;
    end
endmodule
